/* logic/mbp_hold_if.sv */
// Purpose: Carries load, clear and data between the port core and its holding register.
// Assumes: Driven and sampled on the port clock.
// Notes: Width follows the holding register parameter.
`timescale 1ns/1ps
interface mbp_hold_if #(parameter int WIDTH = 8);
  logic load;
  logic clear;
  logic [WIDTH-1:0] dataIn;
  logic [WIDTH-1:0] held;
  modport ctrl (output load, output clear, output dataIn, input held);
  modport store (input load, input clear, input dataIn, output held);
endinterface : mbp_hold_if

/* logic/mbp_hold_reg.sv */
// Purpose: The byte holding register of the port.
// Assumes: Clear takes priority over load.
// Notes: Its output comes straight from flip-flops.
`timescale 1ns/1ps
module mbp_hold_reg
  import mbp_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  mbp_hold_if.store hold
);
  logic [WIDTH-1:0] heldQ;
  logic [WIDTH-1:0] heldD;

  // The register is only as wide as the reset value allows.
  if (WIDTH != DATA_W) begin : gWidthCheck
    $error("mbp_hold_reg: WIDTH must equal DATA_W");
  end

  // Clear empties the register, load copies the input, otherwise it holds.
  always_comb begin
    heldD = heldQ;
    if (hold.clear) begin
      heldD = HOLD_RESET;
    end else if (hold.load) begin
      heldD = hold.dataIn;
    end
  end

  // Registers the next value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      heldQ <= HOLD_RESET;
    end else begin
      heldQ <= heldD;
    end
  end

  assign hold.held = heldQ;
endmodule : mbp_hold_reg

/* logic/mbp_pkg.sv */
// Purpose: Shared constants for the mode programmable byte port.
// Assumes: One clock domain; all port inputs except the asynchronous reset are synchronous to it.
// Notes: Mode codes, data width and the hold and request reset values live here only.
package mbp_pkg;
  localparam int DATA_W = 8;
  localparam logic MODE_INPUT = 1'h0;
  localparam logic MODE_OUTPUT = 1'h1;
  localparam logic [DATA_W-1:0] HOLD_RESET = 8'h00;
  localparam logic REQ_IDLE = 1'h0;
endpackage : mbp_pkg

/* logic/mbp_port.sv */
// Purpose: Mode programmable 8-bit parallel port with a service request flag.
// Assumes: Strobe, selects, clear and data are synchronous to clk at 25 MHz.
// Notes: Strobe level and edges are sampled, so an edge shows one cycle late.
`timescale 1ns/1ps

module mbp_port
  import mbp_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode,
  input wire logic clear,
  input wire logic strobe,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut,
  output logic dataOutEn,
  output logic service_request_n
);
  logic strobeQ;
  logic strobeD;
  logic selQ;
  logic selD;
  logic reqQ;
  logic reqD;
  logic selected;
  logic strobeFall;
  logic selFall;
  logic loadNow;

  mbp_hold_if #(.WIDTH(WIDTH)) hold ();

  // Only the documented byte width is served.
  if (WIDTH != DATA_W) begin : gWidthCheck
    $error("mbp_port: WIDTH must equal DATA_W");
  end

  mbp_hold_reg #(.WIDTH(WIDTH)) uHold (
    .clk(clk),
    .rst(rst),
    .hold(hold.store)
  );

  // Combined select and the edges that drive the request flag.
  assign selected = !select_first_n && select_second;
  assign strobeFall = strobeQ && !strobe;
  assign selFall = selQ && !selected;

  // Load term depends on the strapped mode.
  always_comb begin
    if (mode == MODE_INPUT) begin
      loadNow = strobe;
    end else begin
      loadNow = selected && strobe;
    end
  end

  // Holding register requests; once strobe drops, the last byte stays held.
  assign hold.load = loadNow;
  assign hold.clear = clear;
  assign hold.dataIn = dataIn;

  // Request flag: strobe fall sets it, select fall clears it, set wins.
  always_comb begin
    strobeD = strobe;
    selD = selected;
    reqD = reqQ;
    if (clear) begin
      reqD = REQ_IDLE;
    end else if (strobeFall) begin
      reqD = 1'h1;
    end else if (selFall) begin
      reqD = REQ_IDLE;
    end
  end

  // Registers the edge history and the flag.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobeQ <= 1'h0;
      selQ <= 1'h0;
      reqQ <= REQ_IDLE;
    end else begin
      strobeQ <= strobeD;
      selQ <= selD;
      reqQ <= reqD;
    end
  end

  // Outputs: data from the register, enable by mode, request active low.
  assign dataOut = hold.held;
  assign dataOutEn = (mode == MODE_OUTPUT) ? 1'h1 : selected;
  assign service_request_n = !reqQ;

  // Checks below run on the port clock and are silent while reset is held.
  // Edge events are named once so that each property reads as one event.
  // The edge event sequences require clear low, since clear beats every other event.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Strobe fell at this edge and clear is low.
  sequence strobeFallSeq;
    strobeQ && !strobe && !clear;
  endsequence

  // Combined select fell at this edge with no strobe fall and no clear.
  sequence selFallOnlySeq;
    selQ && !selected && !(strobeQ && !strobe) && !clear;
  endsequence

  // Strobe and combined select fell together at this edge.
  sequence bothFallSeq;
    strobeQ && !strobe && selQ && !selected && !clear;
  endsequence

  // Neither edge is present and clear is low.
  sequence quietSeq;
    !(strobeQ && !strobe) && !(selQ && !selected) && !clear;
  endsequence

  // Output mode select term ended with no strobe fall and no clear.
  sequence outSelEndSeq;
    (mode == MODE_OUTPUT) && selQ && !selected && !(strobeQ && !strobe) && !clear;
  endsequence

  // A lone select fall followed by a cycle with no strobe fall.
  sequence holdOffSeq;
    selFallOnlySeq ##1 (!strobeFall || clear);
  endsequence

  // Clear followed by a cycle with no strobe fall.
  sequence clearQuietSeq;
    clear ##1 (!strobeFall || clear);
  endsequence

  // Input mode strobe high, so the register follows the data inputs.
  sequence inLoadSeq;
    (mode == MODE_INPUT) && strobe && !clear;
  endsequence

  // Input mode strobe low, so the last byte must stay latched.
  sequence inIdleSeq;
    (mode == MODE_INPUT) && !strobe && !clear;
  endsequence

  // Output mode full select with strobe, so the register loads.
  sequence outLoadSeq;
    (mode == MODE_OUTPUT) && selected && strobe && !clear;
  endsequence

  // Output mode without the full select and strobe, so nothing loads.
  sequence outIdleSeq;
    (mode == MODE_OUTPUT) && !(selected && strobe) && !clear;
  endsequence

  // Strobe fall raises the request one cycle later.
  reqSet_a: assert property (strobeFallSeq |=> !service_request_n)
    else $error("request not raised after strobe fall");

  // A lone select fall drops the request one cycle later.
  reqClear_a: assert property (selFallOnlySeq |=> service_request_n)
    else $error("request not dropped after select fall");

  // Once dropped, the request stays off while no strobe fall arrives.
  reqHold_a: assert property (holdOffSeq |=> service_request_n)
    else $error("request returned without a strobe fall");

  // Clear empties the register and drops the request.
  clearPort_a: assert property (clear |=> (dataOut == HOLD_RESET) && service_request_n)
    else $error("clear did not reset register and request");

  // Input mode copies the data inputs while strobe is high.
  inLoad_a: assert property (inLoadSeq |=> dataOut == $past(dataIn))
    else $error("input mode byte not loaded");

  // Output mode copies the data inputs on full select and strobe.
  outLoad_a: assert property (outLoadSeq |=> dataOut == $past(dataIn))
    else $error("output mode byte not loaded");

  // Output mode keeps the byte when select or strobe is missing.
  outHold_a: assert property (outIdleSeq |=> $stable(dataOut))
    else $error("output mode byte changed without select and strobe");

  // Input mode drives the data pins only under the combined select.
  inEnable_a: assert property ((mode == MODE_INPUT) |-> dataOutEn == selected)
    else $error("input mode enable does not follow select");

  // Output mode drives the data pins all the time.
  outEnable_a: assert property ((mode == MODE_OUTPUT) |-> dataOutEn)
    else $error("output mode drivers not enabled");

  // After clear the request stays off until a strobe fall.
  idleAfter_a: assert property (clearQuietSeq |=> service_request_n)
    else $error("request active after clear without event");

  // When both edges fall together the set wins.
  setWins_a: assert property (bothFallSeq |=> !service_request_n)
    else $error("request not raised when strobe and select fell together");

  // With no edge and no clear the request keeps its level.
  reqSteady_a: assert property (quietSeq |=> $stable(service_request_n))
    else $error("request changed without an event");

  // Clear beats a strobe fall on the same edge.
  clearWins_a: assert property (clear && strobeQ && !strobe |=> service_request_n)
    else $error("strobe fall won over clear");

  // Output mode request returns high when the select term ends.
  outReqEnd_a: assert property (outSelEndSeq |=> service_request_n)
    else $error("output mode request not high after select end");

  // Input mode keeps the latched byte while strobe is low.
  inKeep_a: assert property (inIdleSeq |=> $stable(dataOut))
    else $error("input mode byte changed with strobe low");

  // Input mode data pins float without the combined select.
  inFloat_a: assert property ((mode == MODE_INPUT) && !selected |-> !dataOutEn)
    else $error("input mode drivers enabled without select");
endmodule : mbp_port

/* sim/mbp_peer.sv */
// Purpose: Peripheral and processor side of the byte port bus.
// Assumes: Lines change one step after a rising edge.
// Notes: A byte not strobed shows its inverse.
`timescale 1ns/1ps
module mbp_peer
  import mbp_pkg::*;
(
  input wire logic clk,
  output logic strobe,
  output logic select_first_n,
  output logic select_second,
  output logic [DATA_W-1:0] dataIn
);
  // The bus starts idle with nothing selected.
  initial begin
    strobe = 1'h0;
    select_first_n = 1'h1;
    select_second = 1'h0;
    dataIn = 8'h00;
  end
  // One bus step; released data is inverted so stale bytes never match.
  task automatic drive(input logic s1n, input logic s2, input logic st, input logic [7:0] d);
    @(posedge clk);
    #1;
    select_first_n = s1n;
    select_second = s2;
    strobe = st;
    dataIn = st ? d : ~d;
  endtask : drive
endmodule : mbp_peer

/* sim/tb_mode_programmable_byte_port.sv */
// Purpose: Self-checking bench for the byte port.
// Assumes: The peer drives the bus one step after each edge.
// Notes: Table rows cover loads and enables.
`timescale 1ns/1ps
module tb_mode_programmable_byte_port
  import mbp_pkg::*;
;
  typedef struct packed {logic m; logic s1n; logic s2; logic st;
    logic [7:0] d; logic [7:0] q; logic en;} mbp_row_t;
  logic clk, rst, mode, clear, strobe, select_first_n, select_second;
  logic dataOutEn, service_request_n;
  logic [7:0] dataIn, dataOut;
  int errorCnt = 0;
  int cmpCount = 0;
  mbp_row_t rows [6] = '{'{1'h0, 1'h1, 1'h0, 1'h1, 8'hA5, 8'hA5, 1'h0},
    '{1'h0, 1'h0, 1'h1, 1'h0, 8'h3C, 8'hA5, 1'h1}, '{1'h1, 1'h0, 1'h1, 1'h1, 8'h5A, 8'h5A, 1'h1},
    '{1'h1, 1'h1, 1'h1, 1'h1, 8'hC3, 8'h5A, 1'h1}, '{1'h1, 1'h0, 1'h0, 1'h1, 8'hC3, 8'h5A, 1'h1},
    '{1'h1, 1'h0, 1'h1, 1'h0, 8'hC3, 8'h5A, 1'h1}};
  mbp_port i_mbp_port (.clk, .rst, .mode, .clear, .strobe, .select_first_n, .select_second,
    .dataIn, .dataOut, .dataOutEn, .service_request_n);
  mbp_peer i_mbp_peer (.clk, .strobe, .select_first_n, .select_second, .dataIn);
  // Free-running 25 MHz clock.
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Prints the verdict and ends the run.
  task automatic summarize();
    if (errorCnt == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // A hang counts as a mismatch.
  initial begin
    #20000;
    errorCnt++;
    summarize();
  end
  // Reset, table rows, request flag in both modes, then clear.
  initial begin
    mode = 1'h0;
    clear = 1'h0;
    rst = 1'h1;
    repeat (4) @(posedge clk);
    #1 rst = 1'h0;
    chk("rst out", 8'h00, dataOut);
    chk("rst req", 8'h01, {7'h00, service_request_n});
    foreach (rows[i]) begin
      mode = rows[i].m;
      i_mbp_peer.drive(rows[i].s1n, rows[i].s2, rows[i].st, rows[i].d);
      @(posedge clk);
      #1;
      chk("out", rows[i].q, dataOut);
      chk("en", {7'h00, rows[i].en}, {7'h00, dataOutEn});
    end
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      i_mbp_peer.drive(1'h1, 1'h0, 1'h1, 8'h96);
      i_mbp_peer.drive(1'h1, 1'h0, 1'h0, 8'h96);
      repeat (2) @(posedge clk);
      #1;
      chk("req set", 8'h00, {7'h00, service_request_n});
      i_mbp_peer.drive(1'h0, 1'h1, 1'h0, 8'h69);
      i_mbp_peer.drive(1'h1, 1'h1, 1'h0, 8'h69);
      repeat (2) @(posedge clk);
      #1;
      chk("req end", 8'h01, {7'h00, service_request_n});
    end
    i_mbp_peer.drive(1'h1, 1'h0, 1'h1, 8'h77);
    i_mbp_peer.drive(1'h1, 1'h0, 1'h0, 8'h77);
    repeat (2) @(posedge clk);
    #1 clear = 1'h1;
    @(posedge clk);
    #1 clear = 1'h0;
    chk("clr out", 8'h00, dataOut);
    chk("clr req", 8'h01, {7'h00, service_request_n});
    // Strobe and select end on one edge: the set wins.
    i_mbp_peer.drive(1'h0, 1'h1, 1'h1, 8'h3C);
    i_mbp_peer.drive(1'h1, 1'h0, 1'h0, 8'h3C);
    @(posedge clk);
    #1;
    chk("both req", 8'h00, {7'h00, service_request_n});
    chk("both out", 8'h3C, dataOut);
    // Clear on the edge of a strobe fall beats the set.
    i_mbp_peer.drive(1'h1, 1'h0, 1'h1, 8'hE1);
    i_mbp_peer.drive(1'h1, 1'h0, 1'h0, 8'hE1);
    clear = 1'h1;
    @(posedge clk);
    #1 clear = 1'h0;
    chk("clr set req", 8'h01, {7'h00, service_request_n});
    chk("clr set out", 8'h00, dataOut);
    summarize();
  end
endmodule : tb_mode_programmable_byte_port
